// file: include/ecp_defs.svh
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH

// ****************************************************************
// Register offsets within each base window
// ****************************************************************
`define ECP_OFF_DATA      2'h0
`define ECP_OFF_STATUS    2'h1
`define ECP_OFF_CONTROL   2'h2
`define ECP_OFF_FIFO      2'h0
`define ECP_OFF_CAP_B     2'h1
`define ECP_OFF_EXT_CTRL  2'h2

// ****************************************************************
// Mode codes held in extended_control bits 7 to 5
// ****************************************************************
`define ECP_MODE_STD      3'h0
`define ECP_MODE_BIDIR    3'h1
`define ECP_MODE_COMPAT_FIFO_PORT    3'h2
`define ECP_MODE_ECP      3'h3
`define ECP_MODE_TEST     3'h6
`define ECP_MODE_CONFIG   3'h7

// ****************************************************************
// Field positions and fixed values
// ****************************************************************
`define ECP_DCR_DIR       5
`define ECP_DCR_IRQE      4
`define ECP_DCR_SELIN     3
`define ECP_DCR_INIT      2
`define ECP_DCR_AUTOFD    1
`define ECP_DCR_STROBE    0
`define ECP_CAP_A_VAL     8'h10
`define ECP_CAP_B_VAL     8'h00
`define ECP_DSR_LOW_ONES  3'h7
`define ECP_DCR_HIGH_ONES 2'h3

// ****************************************************************
// FIFO shape and handshake timing
// ****************************************************************
`define ECP_FIFO_DEPTH    16
`define ECP_FIFO_AW       4
`define ECP_CLK_NS        10
`define ECP_SETUP_NS      500
`define ECP_STROBE_NS     500
`define ECP_SETUP_CYC     ((`ECP_SETUP_NS + `ECP_CLK_NS - 1) / `ECP_CLK_NS)
`define ECP_STROBE_CYC    ((`ECP_STROBE_NS + `ECP_CLK_NS - 1) / `ECP_CLK_NS)

`endif

// file: include/ecp_pkg.sv
`include "ecp_defs.svh"

package ecp_pkg;

	typedef enum logic [2:0] {
		ENG_IDLE,
		ENG_SETUP,
		ENG_STROBE,
		ENG_HOLD,
		ENG_REQ,
		ENG_ACKWAIT
	} ecp_eng_t;

	typedef struct packed {
		logic [12:0]                              sync1;
		logic [12:0]                              sync2;
		logic [7:0]                               data_latch;
		logic [5:0]                               dcr;
		logic [2:0]                               mode;
		logic [2:0]                               ecr_ctl;
		logic [`ECP_FIFO_DEPTH-1:0][8:0]          mem;
		logic [`ECP_FIFO_AW-1:0]                  wr_ptr;
		logic [`ECP_FIFO_AW-1:0]                  rd_ptr;
		logic [`ECP_FIFO_AW:0]                    count;
		logic [7:0]                               last_rd;
		ecp_eng_t                                 eng;
		logic [7:0]                               cnt;
		logic [8:0]                               xfer;
		logic                                     irq;
		logic                                     ack_last;
		logic [7:0]                               rd_data;
		logic                                     rd_valid;
	} ecp_state_t;

endpackage

// file: rtl/ecp_port.sv
// Function
// - Extended control bits 7:5 select standard, bidir, FIFO, ECP, test, config.
// - Standard mode holds the FIFO in reset and forces direction to forward.
// - Bidir mode: direction 1 floats data lines; data reads return live lines.
// - FIFO mode sends queued bytes with standard strobe handshake, forward only.
// - ECP forward sends shared FIFO bytes; ECP reverse fills the FIFO.
// - Test mode FIFO is readable and writable, shown on lines, never sent.
// - Full test FIFO drops writes; empty read returns the last byte read.
// - Address/RLE port bytes are queued tagged, only while direction is forward.
// - Data latch clears on reset, drives lines non-inverted, reads back.
// - Status reads inverted busy, raw ack, paper, select, fault, low bits one.
// - Control bits 7:6 read one; bits 5:0 clear during reset.
// - Control bit 5 sets direction; ignored in standard and FIFO modes.
// - With control bit 4 set, each ack rising edge raises an interrupt.
// - Control bits drive select-in, auto-feed, strobe inverted and init direct.
// - ECP reverse reads peripheral bytes into the FIFO by automatic handshake.
// - Capability A is read-only and returns 10h.
// - Capability B is read-only and returns zero in the defined fields.
// - Only configuration mode maps capability A and B at second base 0 and 1.
// - Forward: host strobes each byte, busy paces, auto-feed marks command.
// - Reverse: peripheral clocks with ack, host requests with auto-feed.
// - Host drives init low for reverse; select-in stays high in ECP mode.
// - One 16-byte FIFO serves both transfer directions.
// - Extended control bit 1 shows full and bit 0 shows empty, read-only.
`timescale 1ns/1ns
`include "ecp_defs.svh"
module ecp_port
	import ecp_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Host register access
	input  wire logic        reg_base2,
	input  wire logic [1:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	output logic             irq_pulse,
	// Parallel data lines
	input  wire logic [7:0]  parallel_data_lines_in,
	output logic      [7:0]  parallel_data_lines_out,
	output logic             parallel_data_lines_oe,
	// Peripheral status inputs
	input  wire logic        busy,
	input  wire logic        ack_n,
	input  wire logic        perror,
	input  wire logic        select,
	input  wire logic        fault_n,
	// Peripheral control outputs
	output logic             strobe_n,
	output logic             autofd_n,
	output logic             init_n,
	output logic             selin_n
);

	localparam logic [7:0] SETUP_CYC  = 8'(`ECP_SETUP_CYC);
	localparam logic [7:0] STROBE_CYC = 8'(`ECP_STROBE_CYC);
	localparam logic [4:0] FIFO_FULL  = 5'(`ECP_FIFO_DEPTH);

	ecp_state_t st_q;
	ecp_state_t st_d;

	logic [7:0] pd_s;
	logic       busy_s;
	logic       ack_s;
	logic       perr_s;
	logic       sel_s;
	logic       fault_s;
	logic       dir;
	logic       full;
	logic       empty;
	logic       fwd_auto;
	logic       rev_auto;
	logic       fifo_clr;

	// ************************************************************
	// Synchronised pins and mode decode
	// ************************************************************
	assign {pd_s, busy_s, ack_s, perr_s, sel_s, fault_s} = st_q.sync2;
	// Direction only counts where the mode allows it to be set.
	assign dir = (st_q.mode == `ECP_MODE_BIDIR ||
		st_q.mode == `ECP_MODE_ECP || st_q.mode == `ECP_MODE_TEST ||
		st_q.mode == `ECP_MODE_CONFIG) && st_q.dcr[`ECP_DCR_DIR];
	assign full  = st_q.count == FIFO_FULL;
	assign empty = st_q.count == 5'h00;
	// Reserved codes fall in with standard mode and clear the FIFO.
	assign fifo_clr = st_q.mode == `ECP_MODE_STD ||
		st_q.mode == 3'h4 || st_q.mode == 3'h5;
	assign fwd_auto = (st_q.mode == `ECP_MODE_COMPAT_FIFO_PORT) ||
		(st_q.mode == `ECP_MODE_ECP && !dir);
	assign rev_auto = st_q.mode == `ECP_MODE_ECP && dir;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic       push;
		logic [8:0] push_val;
		logic       pop;
		logic       hrd;
		logic       hwr;
		st_d     = st_q;
		push     = 1'b0;
		push_val = 9'h000;
		pop      = 1'b0;
		hrd      = reg_rd && !reg_wr;
		hwr      = reg_wr;
		st_d.sync1    = {parallel_data_lines_in, busy, ack_n, perror,
			select, fault_n};
		st_d.sync2    = st_q.sync1;
		st_d.rd_valid = hrd;
		// The edge is taken behind the synchroniser, so a metastable
		// first stage can never fire the interrupt.
		st_d.ack_last = ack_s;
		st_d.irq      = st_q.dcr[`ECP_DCR_IRQE] && ack_s &&
			!st_q.ack_last;

		// Host writes.
		if (hwr) begin
			if (!reg_base2) begin
				case (reg_addr)
					`ECP_OFF_DATA: begin
						if (st_q.mode == `ECP_MODE_ECP) begin
							if (!dir) begin
								push     = 1'b1;
								push_val = {1'b1, reg_wdata};
							end
						end else begin
							st_d.data_latch = reg_wdata;
						end
					end
					`ECP_OFF_CONTROL: st_d.dcr = reg_wdata[5:0];
					default: ;
				endcase
			end else begin
				case (reg_addr)
					`ECP_OFF_FIFO: begin
						if (st_q.mode == `ECP_MODE_COMPAT_FIFO_PORT ||
							st_q.mode == `ECP_MODE_TEST ||
							(st_q.mode == `ECP_MODE_ECP && !dir)) begin
							push     = 1'b1;
							push_val = {1'b0, reg_wdata};
						end
					end
					`ECP_OFF_EXT_CTRL: begin
						st_d.mode    = reg_wdata[7:5];
						st_d.ecr_ctl = reg_wdata[4:2];
					end
					default: ;
				endcase
			end
		end

		// Host reads, answered from a register one cycle later.
		st_d.rd_data = 8'h00;
		if (hrd) begin
			if (!reg_base2) begin
				case (reg_addr)
					`ECP_OFF_DATA: st_d.rd_data =
						(st_q.mode == `ECP_MODE_BIDIR && dir) ?
						pd_s : st_q.data_latch;
					`ECP_OFF_STATUS: st_d.rd_data = {!busy_s, ack_s,
						perr_s, sel_s, fault_s, `ECP_DSR_LOW_ONES};
					`ECP_OFF_CONTROL: st_d.rd_data =
						{`ECP_DCR_HIGH_ONES, st_q.dcr};
					default: st_d.rd_data = 8'h00;
				endcase
			end else begin
				case (reg_addr)
					`ECP_OFF_FIFO: begin
						if (st_q.mode == `ECP_MODE_CONFIG) begin
							st_d.rd_data = `ECP_CAP_A_VAL;
						end else if (st_q.mode == `ECP_MODE_TEST ||
							rev_auto) begin
							if (empty) begin
								st_d.rd_data = st_q.last_rd;
							end else begin
								pop          = 1'b1;
								st_d.rd_data = st_q.mem[st_q.rd_ptr][7:0];
								st_d.last_rd = st_q.mem[st_q.rd_ptr][7:0];
							end
						end
					end
					`ECP_OFF_CAP_B: st_d.rd_data =
						(st_q.mode == `ECP_MODE_CONFIG) ?
						`ECP_CAP_B_VAL : 8'h00;
					`ECP_OFF_EXT_CTRL: st_d.rd_data =
						{st_q.mode, st_q.ecr_ctl, full, empty};
					default: st_d.rd_data = 8'h00;
				endcase
			end
		end

		// Handshake engine: forward strobes bytes out, reverse pulls in.
		case (st_q.eng)
			ENG_IDLE: begin
				if (fwd_auto && !empty && !busy_s && !pop) begin
					pop       = 1'b1;
					st_d.xfer = st_q.mem[st_q.rd_ptr];
					st_d.cnt  = SETUP_CYC;
					st_d.eng  = ENG_SETUP;
				end else if (rev_auto && !full && !push) begin
					st_d.eng = ENG_REQ;
				end
			end
			ENG_SETUP: begin
				if (st_q.cnt <= 8'h01) begin
					st_d.cnt = STROBE_CYC;
					st_d.eng = ENG_STROBE;
				end else begin
					st_d.cnt = st_q.cnt - 8'h01;
				end
			end
			ENG_STROBE: begin
				// ECP peripherals answer the strobe with busy high.
				if (st_q.cnt > 8'h01) begin
					st_d.cnt = st_q.cnt - 8'h01;
				end else if (st_q.mode != `ECP_MODE_ECP || busy_s) begin
					st_d.eng = ENG_HOLD;
				end
			end
			ENG_HOLD: begin
				if (!busy_s) begin
					st_d.eng = ENG_IDLE;
				end
			end
			ENG_REQ: begin
				if (!ack_s) begin
					push     = 1'b1;
					push_val = {busy_s, pd_s};
					st_d.eng = ENG_ACKWAIT;
				end
			end
			ENG_ACKWAIT: begin
				if (ack_s) begin
					st_d.eng = ENG_IDLE;
				end
			end
			default: st_d.eng = ENG_IDLE;
		endcase
		// Leaving forward or reverse automatic mode abandons any transfer in flight;
		// otherwise a forward strobe cut by a turn-round would wait on
		// busy for ever.
		if ((!fwd_auto && (st_q.eng == ENG_SETUP ||
			st_q.eng == ENG_STROBE || st_q.eng == ENG_HOLD)) ||
			(!rev_auto && (st_q.eng == ENG_REQ ||
			st_q.eng == ENG_ACKWAIT))) begin
			st_d.eng = ENG_IDLE;
		end

		// Shared FIFO bookkeeping; writes into a full FIFO are dropped.
		if (push && !full) begin
			st_d.mem[st_q.wr_ptr] = push_val;
			st_d.wr_ptr = st_q.wr_ptr + 4'h1;
		end
		if (pop) begin
			st_d.rd_ptr = st_q.rd_ptr + 4'h1;
		end
		st_d.count = st_q.count + 5'((push && !full) ? 1 : 0)
			- 5'(pop ? 1 : 0);
		if (fifo_clr) begin
			st_d.wr_ptr = 4'h0;
			st_d.rd_ptr = 4'h0;
			st_d.count  = 5'h00;
			st_d.dcr[`ECP_DCR_DIR] = 1'b0;
		end
		if (st_q.mode == `ECP_MODE_COMPAT_FIFO_PORT) begin
			st_d.dcr[`ECP_DCR_DIR] = 1'b0;
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************************
	// Pins and host answer
	// ************************************************************
	assign reg_rdata  = st_q.rd_data;
	assign reg_rvalid = st_q.rd_valid;
	assign irq_pulse  = st_q.irq;

	always_comb begin
		parallel_data_lines_oe  = !dir;
		parallel_data_lines_out = st_q.data_latch;
		strobe_n = !st_q.dcr[`ECP_DCR_STROBE];
		autofd_n = !st_q.dcr[`ECP_DCR_AUTOFD];
		init_n   = st_q.dcr[`ECP_DCR_INIT];
		selin_n  = !st_q.dcr[`ECP_DCR_SELIN];
		if (st_q.mode == `ECP_MODE_TEST) begin
			parallel_data_lines_out = st_q.mem[st_q.rd_ptr][7:0];
		end else if (fwd_auto) begin
			parallel_data_lines_out = st_q.xfer[7:0];
			strobe_n = st_q.eng != ENG_STROBE;
			if (st_q.mode == `ECP_MODE_ECP) begin
				autofd_n = !st_q.xfer[8];
			end
		end
		if (st_q.mode == `ECP_MODE_ECP) begin
			selin_n = 1'b1;
			if (rev_auto) begin
				strobe_n = 1'b1;
				autofd_n = st_q.eng != ENG_REQ;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	std_dir_a: assert property (
		st_q.mode == `ECP_MODE_STD |=> !st_q.dcr[`ECP_DCR_DIR] && empty)
		else $error("standard mode left direction or FIFO set");
	bidir_float_a: assert property (
		st_q.mode == `ECP_MODE_BIDIR && st_q.dcr[`ECP_DCR_DIR]
		|-> !parallel_data_lines_oe)
		else $error("data lines driven in bidir input");
	test_drop_a: assert property (
		full && reg_wr && reg_base2 && reg_addr == `ECP_OFF_FIFO &&
		st_q.mode == `ECP_MODE_TEST && !reg_rd |=> full)
		else $error("full test FIFO lost its fill");
	afifo_rev_a: assert property (
		st_q.mode == `ECP_MODE_ECP && dir && reg_wr && !reg_base2 &&
		reg_addr == `ECP_OFF_DATA && (st_q.eng != ENG_REQ || ack_s)
		|=> $stable(st_q.wr_ptr))
		else $error("address port wrote in reverse");
	status_fmt_a: assert property (
		reg_rd && !reg_wr && !reg_base2 && reg_addr == `ECP_OFF_STATUS
		|=> reg_rvalid && reg_rdata[2:0] == 3'h7 &&
		reg_rdata[7] == !$past(busy_s))
		else $error("status read format wrong");
	ctrl_ones_a: assert property (
		reg_rd && !reg_wr && !reg_base2 && reg_addr == `ECP_OFF_CONTROL
		|=> reg_rdata[7:6] == 2'h3)
		else $error("control high bits not one");
	irq_edge_a: assert property (
		irq_pulse |-> $past(st_q.dcr[`ECP_DCR_IRQE]) &&
		$past(st_q.sync2[3]) && !$past(st_q.sync2[3], 2))
		else $error("interrupt without ack rise");
	init_pin_a: assert property (
		init_n == st_q.dcr[`ECP_DCR_INIT])
		else $error("init pin not following control");
	cap_a_a: assert property (
		reg_rd && !reg_wr && reg_base2 && reg_addr == `ECP_OFF_FIFO &&
		st_q.mode == `ECP_MODE_CONFIG |=> reg_rdata == 8'h10)
		else $error("capability A wrong");
	selin_ecp_a: assert property (
		st_q.mode == `ECP_MODE_ECP |-> selin_n)
		else $error("select-in low in ECP mode");
	strobe_len_a: assert property (
		$fell(strobe_n) && fwd_auto |-> !strobe_n [*8])
		else $error("forward strobe too short");
	rsvd_idle_a: assert property (
		st_q.mode == 3'h4 || st_q.mode == 3'h5
		|=> empty && st_q.eng == ENG_IDLE)
		else $error("reserved mode left the FIFO busy");
	test_quiet_a: assert property (
		st_q.mode == `ECP_MODE_TEST |=> st_q.eng == ENG_IDLE)
		else $error("test mode ran the handshake engine");
	rev_req_a: assert property (
		rev_auto && st_q.eng == ENG_REQ |-> !autofd_n && strobe_n)
		else $error("reverse request not shown on auto-feed");

	fwd_send_c: cover property (st_q.eng == ENG_HOLD ##[1:50] !busy_s);
	rev_fill_c: cover property (st_q.eng == ENG_REQ ##[1:50] rev_auto && !empty);
	test_full_c: cover property (st_q.mode == `ECP_MODE_TEST && full);
	irq_seen_c: cover property (irq_pulse && rev_auto);

endmodule

// file: sim/ecp_periph_model.sv
`timescale 1ns/1ns
// ****
// Behavioural peripheral on the cable
// ****
module ecp_periph_model (
	// Clock
	input  wire logic             core_clk,
	// Host pins
	input  wire logic             strobe_n,
	input  wire logic             autofd_n,
	input  wire logic             init_n,
	input  wire logic             selin_n,
	input  wire logic [7:0]       lines,
	// Scenario control
	input  wire logic             slow,
	input  wire logic [1:0]       rev_cnt,
	// Peripheral pins
	output logic                  busy,
	output logic                  ack_n,
	output logic                  perror,
	output logic      [7:0]       pdata,
	output logic                  pdrive,
	// Observation
	output logic      [3:0][8:0]  fwd_log,
	output logic      [2:0]       fwd_n,
	output logic      [1:0]       rev_sent
);
	logic [7:0] last;
	int         dly;

	// A released bus shows the inverse of the last byte, never a guess.
	assign pdata = pdrive ? last : ~last;
	assign dly   = slow ? 20 : 2;

	initial begin
		busy = 0; ack_n = 1; perror = 1; pdrive = 0;
		last = 0; fwd_n = 0; rev_sent = 0; fwd_log = '0;
		forever begin
			@(posedge core_clk);
			if (!strobe_n) begin
				fwd_log[fwd_n[1:0]] <= {autofd_n, lines};
				fwd_n <= fwd_n + 3'h1;
				repeat (dly) @(posedge core_clk);
				busy <= 1'b1;
				for (int i = 0; i < 400 && !strobe_n; i++) @(posedge core_clk);
				repeat (dly) @(posedge core_clk);
				busy <= 1'b0;
			end else if (!init_n && selin_n && !autofd_n && rev_sent < rev_cnt) begin
				perror <= 1'b0;
				pdrive <= 1'b1;
				last <= 8'hC3 ^ {6'h0, rev_sent};
				busy <= rev_sent[0];
				repeat (dly) @(posedge core_clk);
				ack_n <= 1'b0;
				for (int i = 0; i < 400 && !autofd_n; i++) @(posedge core_clk);
				ack_n <= 1'b1;
				rev_sent <= rev_sent + 2'h1;
				repeat (2) @(posedge core_clk);
			end else if (init_n) begin
				perror <= 1'b1;
				pdrive <= 1'b0;
			end
		end
	end
endmodule

// file: sim/test_ecp_port.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; \
	if ((got) !== (ex)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module test_ecp_port;
	import ecp_pkg::*;
	logic             core_clk, sys_rst, reg_base2, reg_wr, reg_rd;
	logic [1:0]       reg_addr, rev_cnt;
	logic [7:0]       reg_wdata, reg_rdata, pdl_out, pdata, rd_v;
	logic             reg_rvalid, irq_pulse, pdl_oe, select, fault_n, slow;
	logic             busy, ack_n, perror, pdrive;
	logic             strobe_n, autofd_n, init_n, selin_n;
	logic [3:0][8:0]  fwd_log;
	logic [2:0]       fwd_n, base;
	logic [1:0]       rev_sent;
	wire  [7:0]       lines = pdl_oe ? pdl_out : pdata;
	int               mismatches, tests_run, irqs;

	ecp_port u_ecp_port (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_base2(reg_base2), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .irq_pulse(irq_pulse),
		.parallel_data_lines_in(lines), .parallel_data_lines_out(pdl_out),
		.parallel_data_lines_oe(pdl_oe), .busy(busy), .ack_n(ack_n),
		.perror(perror), .select(select), .fault_n(fault_n),
		.strobe_n(strobe_n), .autofd_n(autofd_n), .init_n(init_n),
		.selin_n(selin_n));
	ecp_periph_model u_ecp_periph_model (.core_clk(core_clk),
		.strobe_n(strobe_n), .autofd_n(autofd_n), .init_n(init_n),
		.selin_n(selin_n), .lines(lines), .slow(slow), .rev_cnt(rev_cnt),
		.busy(busy), .ack_n(ack_n), .perror(perror), .pdata(pdata),
		.pdrive(pdrive), .fwd_log(fwd_log), .fwd_n(fwd_n),
		.rev_sent(rev_sent));

	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (irq_pulse === 1'b1) irqs++;

	// ****
	// Register access and closing
	// ****
	task wr(input logic b, input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_base2 <= b; reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task chk_rd(input logic b, input logic [1:0] a, input logic [7:0] ex);
		@(posedge core_clk);
		reg_base2 <= b; reg_addr <= a; reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("rvalid", 1'b1, reg_rvalid)
		`CHK("rdata", ex, reg_rdata)
	endtask
	task wrap_up;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wait_fwd(input logic [2:0] n);
		for (int i = 0; i < 3000 && fwd_n != n; i++) @(posedge core_clk);
		`CHK("fwd count", n, fwd_n)
		if (fwd_n != n) wrap_up();
	endtask

	// ****
	// Scenarios
	// ****
	task t_reset;
		`CHK("pins", 4'b1101, {strobe_n, autofd_n, init_n, selin_n})
		`CHK("out", 9'h100, {pdl_oe, pdl_out})
		chk_rd(0, 2'h1, 8'hF7);
		@(posedge core_clk);
		select <= 0; fault_n <= 1;
		repeat (3) @(posedge core_clk);
		chk_rd(0, 2'h1, 8'hEF);
		chk_rd(0, 2'h2, 8'hC0);
		chk_rd(1, 2'h2, 8'h01);
	endtask
	task t_latch;
		wr(0, 2'h0, 8'hA5);
		`CHK("out", 8'hA5, pdl_out)
		chk_rd(0, 2'h0, 8'hA5);
		wr(0, 2'h2, 8'hEF);
		chk_rd(0, 2'h2, 8'hCF);
		`CHK("oe", 1'b1, pdl_oe)
		`CHK("pins", 4'b0010, {strobe_n, autofd_n, init_n, selin_n})
		wr(0, 2'h2, 8'h00);
		repeat (60) @(posedge core_clk);
	endtask
	task t_bidir;
		wr(1, 2'h2, 8'h20);
		wr(0, 2'h2, 8'h20);
		`CHK("oe", 1'b0, pdl_oe)
		repeat (3) @(posedge core_clk);
		chk_rd(0, 2'h0, 8'hFF);
		chk_rd(0, 2'h2, 8'hE0);
		wr(0, 2'h2, 8'h00);
	endtask
	task t_test;
		base = fwd_n;
		wr(1, 2'h2, 8'hC0);
		for (int i = 0; i < 17; i++) wr(1, 2'h0, 8'h30 + 8'(i));
		chk_rd(1, 2'h2, 8'hC2);
		`CHK("head", 8'h30, lines)
		`CHK("sent", base, fwd_n)
		for (int i = 0; i < 16; i++) chk_rd(1, 2'h0, 8'h30 + 8'(i));
		chk_rd(1, 2'h2, 8'hC1);
		chk_rd(1, 2'h0, 8'h3F);
		wr(1, 2'h0, 8'h77);
		wr(1, 2'h2, 8'h00);
		chk_rd(1, 2'h2, 8'h01);
	endtask
	task t_cap;
		wr(1, 2'h2, 8'hE0);
		chk_rd(1, 2'h0, 8'h10);
		wr(1, 2'h0, 8'h55);
		chk_rd(1, 2'h0, 8'h10);
		chk_rd(1, 2'h1, 8'h00);
		wr(1, 2'h2, 8'h80);
		wr(1, 2'h0, 8'h66);
		chk_rd(1, 2'h2, 8'h81);
		`CHK("out", 9'h1A5, {pdl_oe, pdl_out})
		wr(1, 2'h2, 8'h00);
	endtask
	task t_compat_fifo_port;
		// A slow peripheral makes the engine stall on busy.
		slow <= 1;
		base = fwd_n;
		wr(1, 2'h2, 8'h40);
		wr(0, 2'h2, 8'h20);
		chk_rd(0, 2'h2, 8'hC0);
		wr(1, 2'h0, 8'h81);
		wr(1, 2'h0, 8'h42);
		wait_fwd(base + 3'h2);
		`CHK("b0", 8'h81, fwd_log[base[1:0]][7:0])
		`CHK("b1", 8'h42, fwd_log[base[1:0] + 2'h1][7:0])
		repeat (60) @(posedge core_clk);
		wr(1, 2'h2, 8'h00);
	endtask
	task t_ecp;
		slow <= 0;
		base = fwd_n;
		wr(1, 2'h2, 8'h60);
		wr(0, 2'h0, 8'h7E);
		wr(1, 2'h0, 8'h55);
		wait_fwd(base + 3'h2);
		`CHK("addr", 9'h07E, fwd_log[base[1:0]])
		`CHK("data", 9'h155, fwd_log[base[1:0] + 2'h1])
		`CHK("selin", 1'b1, selin_n)
		// The turn-round goes through mode 001 once the link is quiet.
		repeat (80) @(posedge core_clk);
		irqs = 0;
		rev_cnt <= 2;
		wr(1, 2'h2, 8'h20);
		wr(0, 2'h2, 8'h30);
		wr(1, 2'h2, 8'h60);
		for (int i = 0; i < 3000 && rev_sent != 2; i++) @(posedge core_clk);
		`CHK("rev count", 2'h2, rev_sent)
		if (rev_sent != 2'h2) wrap_up();
		repeat (10) @(posedge core_clk);
		`CHK("irqs", 2, irqs)
		`CHK("oe", 1'b0, pdl_oe)
		chk_rd(1, 2'h0, 8'hC3);
		chk_rd(1, 2'h0, 8'hC2);
		wr(0, 2'h0, 8'h11);
		chk_rd(1, 2'h2, 8'h61);
	endtask

	initial begin
		sys_rst = 1; reg_base2 = 0; reg_addr = 0; reg_wr = 0; reg_rd = 0;
		reg_wdata = 0; select = 1; fault_n = 0; slow = 0; rev_cnt = 0;
		mismatches = 0; tests_run = 0; irqs = 0; base = 0;
		repeat (3) @(posedge core_clk);
		sys_rst <= 0;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_latch();
		t_bidir();
		t_test();
		t_cap();
		t_compat_fifo_port();
		t_ecp();
		wrap_up();
	end
endmodule
